/* hw/line_act_cfg.svh */
// Constants of the line activation state machine
`ifndef LINE_ACT_CFG_SVH
`define LINE_ACT_CFG_SVH

// Layer-2 command codes
`define CMD_DEACT_REQ     4'h0
`define CMD_SW_INIT       4'h1
`define CMD_TEST_SINGLE   4'h2
`define CMD_TEST_CONT     4'h3
`define CMD_ACT_REQ       4'h8
`define CMD_ACT_LOOP2     4'hA
`define CMD_ACT_BLOCKED   4'hC
`define CMD_DEACT_CONFIRM 4'hF

// Layer-2 indication codes
`define IND_CLOCKING      4'h0
`define IND_UNLOCKED      4'h4
`define IND_ACT_REQ       4'h8
`define IND_TERM_ONLY     4'h7
`define IND_ACTIVATED     4'hC
`define IND_QUIET         4'hF

// Status word layout
`define STAT_WIDTH        32
`define STAT_MON_LSB      0
`define STAT_RX_STATE     2
`define STAT_FAR_END      3
`define STAT_SLIP         4
`define STAT_FRAME_LOCK   5
`define STAT_FRAMING_VIOL 6
`define STAT_MFRAME_LOCK  7

// Timing
`define CLK_PERIOD_NS     8
`define QUIET_TIME_NS     2000000
`define QUIET_CYC ((`QUIET_TIME_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define SLOW_RATE_HZ      2000
`define SLOW_CYC (1000000000/(`SLOW_RATE_HZ*`CLK_PERIOD_NS))
`define FAST_RATE_HZ      192000
`define FAST_HALF_CYC (1000000000/(2*`FAST_RATE_HZ*`CLK_PERIOD_NS))
`define GOOD_FRAMES       2'h2

`endif

/* hw/line_act_pkg.sv */
// Types of the line activation state machine
package line_act_pkg;

   typedef enum logic [3:0] {
      ST_RESET      = 4'h0,
      ST_TEST       = 4'h1,
      ST_PEND_DEACT = 4'h2,
      ST_WAIT_DR    = 4'h3,
      ST_DEACT      = 4'h4,
      ST_PEND_ACT   = 4'h5,
      ST_SYNCED     = 4'h6,
      ST_ACTIVATED  = 4'h7,
      ST_RESYNC     = 4'h8
   } lsm_state_e;

   typedef enum logic [1:0] {
      TM_OFF    = 2'h0,
      TM_SINGLE = 2'h1,
      TM_CONT   = 2'h2
   } test_mode_e;

   typedef enum logic [2:0] {
      INFO_0    = 3'h0,
      INFO_2    = 3'h2,
      INFO_4    = 3'h4,
      INFO_TEST = 3'h7
   } info_e;

   typedef struct packed {
      lsm_state_e  st;
      test_mode_e  tmode;
      info_e       info;
      logic        cmd_pend;
      logic [3:0]  cmd;
      logic [1:0]  good;
      logic        tbit;
      logic        wake;
      logic        awake;
      logic [3:0]  ind;
      logic        ind_vld;
      logic        framing_violation_flag;
      logic [31:0] word;
      logic [31:0] sh;
   } core_s;

   typedef struct packed {
      logic [17:0] cnt;
      logic        done;
   } quiet_s;

   typedef struct packed {
      logic [16:0] slow;
      logic [9:0]  fast;
      logic        pol;
      logic        pos;
      logic        neg;
   } pulse_s;

endpackage

/* hw/quiet_timer.sv */
// Continuous quiet-line timer for pending deactivation
`timescale 1ns/1ps
`default_nettype none
`include "line_act_cfg.svh"

module quiet_timer #(
   parameter int QUIET_CYC = `QUIET_CYC
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rstn,
   // Control
   input  wire logic enable,
   input  wire logic line_active,
   // Result
   output logic      quiet_done
);

   localparam logic [17:0] LAST = 18'(QUIET_CYC - 1);

   line_act_pkg::quiet_s q_r;
   line_act_pkg::quiet_s q_nxt;

   always_comb begin
      q_nxt = q_r;
      if (!enable || line_active) begin
         q_nxt = '0;
      end else if (!q_r.done) begin
         if (q_r.cnt == LAST) begin
            q_nxt.done = 1'b1;
         end else begin
            q_nxt.cnt = q_r.cnt + 18'h1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign quiet_done = q_r.done;

endmodule
`default_nettype wire

/* hw/test_pulse_gen.sv */
// Test pulse generator: single or continuous alternating pulses
`timescale 1ns/1ps
`default_nettype none
`include "line_act_cfg.svh"

module test_pulse_gen #(
   parameter int SLOW_CYC = `SLOW_CYC
) (
   // Clock and reset
   input  wire logic                     sys_clk,
   input  wire logic                     rstn,
   // Mode
   input  wire line_act_pkg::test_mode_e mode,
   // Pulse outputs
   output logic                          pulse_pos,
   output logic                          pulse_neg
);

   localparam logic [16:0] SLOW_LAST = 17'(SLOW_CYC - 1);
   localparam logic [9:0]  FAST_LAST = 10'(`FAST_HALF_CYC - 1);
   localparam logic [16:0] WIDTH     = 17'(`FAST_HALF_CYC);

   line_act_pkg::pulse_s p_r;
   line_act_pkg::pulse_s p_nxt;

   always_comb begin
      p_nxt = p_r;
      case (mode)
         line_act_pkg::TM_SINGLE: begin
            // One pulse per slow period, polarity alternating
            p_nxt.fast = '0;
            if (p_r.slow == SLOW_LAST) begin
               p_nxt.slow = '0;
               p_nxt.pol  = ~p_r.pol;
            end else begin
               p_nxt.slow = p_r.slow + 17'h1;
            end
            p_nxt.pos = (p_r.slow < WIDTH) & p_r.pol;
            p_nxt.neg = (p_r.slow < WIDTH) & ~p_r.pol;
         end
         line_act_pkg::TM_CONT: begin
            // Alternating half periods without gaps
            p_nxt.slow = '0;
            if (p_r.fast == FAST_LAST) begin
               p_nxt.fast = '0;
               p_nxt.pol  = ~p_r.pol;
            end else begin
               p_nxt.fast = p_r.fast + 10'h1;
            end
            p_nxt.pos = p_r.pol;
            p_nxt.neg = ~p_r.pol;
         end
         default: begin
            p_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         p_r <= '0;
      end else begin
         p_r <= p_nxt;
      end
   end

   assign pulse_pos = p_r.pos;
   assign pulse_neg = p_r.neg;

endmodule
`default_nettype wire

/* hw/line_activation_state_machine.sv */
// Exchange-side line activation and deactivation state machine
// Summary of operation
// - Reset pin or init command: reset state, silence, awake detector off.
// - Test mode suspends bursts and sends the selected pattern continuously.
// - Code 0010 single pulses at 2 kHz; 0011 continuous at 192 kHz.
// - Code 0000 enters pending deactivation from any state, sending silence.
// - Pending deactivation: detector on; leave after 2 ms quiet or confirm.
// - Unconditional states reach conditional ones only via pending deactivation.
// - Then wait-for-request; proceeds to activation, deactivated or loop.
// - Deactivated keeps detector on; wake signal starts pending activation.
// - Wake or activate command enters pending activation sending INFO 2.
// - INFO 1 received: synchronized within 10 ms, keep sending INFO 2.
// - Two frames without framing violation: activated, sending INFO 4.
// - INFO 3 lost: resync with INFO 2; INFO 1 returns to synchronized.
// - Code 1010 sends INFO 2 with T bit one for test loop 2.
// - Code 1100 sends INFO 4 with T bit zero.
// - Deactivated line carries silence in both directions.
// - Activated line carries INFO 3 up and INFO 4 down continuously.
// - INFO 1 and 2: 4 kHz bursts with framing violation.
// - INFO 3 and 4: 4 kHz bursts, no framing violation, user data.
// - Superframe: violation every fourth frame, S and T bits transparent.
// - 32-bit status word per channel shifted out serially.
// - Indications: 0000, 0100, 1000, 0111, 1100, 1111.
`timescale 1ns/1ps
`default_nettype none
`include "line_act_cfg.svh"

module line_activation_state_machine #(
   parameter int QUIET_CYC = `QUIET_CYC,
   parameter int SLOW_CYC  = `SLOW_CYC
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   // Layer-2 command port
   input  wire logic [3:0]  cmd_code,
   input  wire logic        cmd_strobe,
   // Layer-2 indication port
   output logic [3:0]       ind_code,
   output logic             ind_strobe,
   // Line timing and receiver
   input  wire logic        frame_tick,
   input  wire logic        rx_signal,
   input  wire logic        rx_info1w,
   input  wire logic        rx_info1,
   input  wire logic        rx_frame,
   input  wire logic        rx_frame_cv,
   input  wire logic        rx_info3_lost,
   // Line transmit control
   output logic [2:0]       tx_info,
   output logic             tx_t_bit,
   output logic             tx_pulse_pos,
   output logic             tx_pulse_neg,
   output logic             awake_det_en,
   // Status word
   input  wire logic [1:0]  mon_bits,
   input  wire logic        far_end_violation_flag,
   input  wire logic        slip_flag,
   input  wire logic        multiframe_lock_flag,
   input  wire logic        stat_load,
   output logic             stat_sdo,
   output logic [31:0]      stat_word
);

   // ***********************************************************
   // Decoding helpers
   // ***********************************************************

   function automatic logic is_uncond(line_act_pkg::lsm_state_e s);
      is_uncond = (s == line_act_pkg::ST_RESET) ||
                  (s == line_act_pkg::ST_TEST);
   endfunction

   function automatic line_act_pkg::info_e info_of(
      line_act_pkg::lsm_state_e s);
      case (s)
         line_act_pkg::ST_TEST:      info_of = line_act_pkg::INFO_TEST;
         line_act_pkg::ST_PEND_ACT,
         line_act_pkg::ST_SYNCED,
         line_act_pkg::ST_RESYNC:    info_of = line_act_pkg::INFO_2;
         line_act_pkg::ST_ACTIVATED: info_of = line_act_pkg::INFO_4;
         default:                    info_of = line_act_pkg::INFO_0;
      endcase
   endfunction

   function automatic logic [3:0] ind_of(
      line_act_pkg::lsm_state_e s, logic wake);
      case (s)
         line_act_pkg::ST_WAIT_DR:   ind_of = `IND_QUIET;
         line_act_pkg::ST_PEND_ACT:
            ind_of = wake ? `IND_ACT_REQ : `IND_CLOCKING;
         line_act_pkg::ST_SYNCED:    ind_of = `IND_TERM_ONLY;
         line_act_pkg::ST_ACTIVATED: ind_of = `IND_ACTIVATED;
         line_act_pkg::ST_RESYNC:    ind_of = `IND_UNLOCKED;
         default:                    ind_of = `IND_CLOCKING;
      endcase
   endfunction

   // ***********************************************************
   // State and helper blocks
   // ***********************************************************

   line_act_pkg::core_s c_r;
   line_act_pkg::core_s c_nxt;
   logic                cmd_now;
   logic                quiet_done;
   logic [31:0]         stat_now;
   logic [3:0]          ind_new;

   assign cmd_now = c_r.cmd_pend & frame_tick;

   quiet_timer #(
      .QUIET_CYC   (QUIET_CYC)
   ) u_quiet (
      .sys_clk     (sys_clk),
      .rstn        (rstn),
      .enable      (c_r.st == line_act_pkg::ST_PEND_DEACT),
      .line_active (rx_signal),
      .quiet_done  (quiet_done)
   );

   test_pulse_gen #(
      .SLOW_CYC  (SLOW_CYC)
   ) u_pulse (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .mode      (c_r.tmode),
      .pulse_pos (tx_pulse_pos),
      .pulse_neg (tx_pulse_neg)
   );

   // ***********************************************************
   // Status word; top three flags serve test only
   // ***********************************************************

   always_comb begin
      stat_now = '0;
      stat_now[`STAT_MON_LSB +: 2] = mon_bits;
      stat_now[`STAT_RX_STATE] = (c_r.st == line_act_pkg::ST_ACTIVATED);
      stat_now[`STAT_FAR_END] = far_end_violation_flag;
      stat_now[`STAT_SLIP] = slip_flag;
      stat_now[`STAT_FRAME_LOCK] = (c_r.st == line_act_pkg::ST_SYNCED) ||
                                   (c_r.st == line_act_pkg::ST_ACTIVATED);
      stat_now[`STAT_FRAMING_VIOL] = c_r.framing_violation_flag;
      stat_now[`STAT_MFRAME_LOCK] = multiframe_lock_flag;
   end

   // ***********************************************************
   // Next state
   // ***********************************************************

   always_comb begin
      c_nxt = c_r;
      c_nxt.ind_vld = 1'b0;
      ind_new = '0;

      // Command latch; a new strobe wins over the consuming edge
      if (cmd_strobe) begin
         c_nxt.cmd_pend = 1'b1;
         c_nxt.cmd = cmd_code;
      end else if (cmd_now) begin
         c_nxt.cmd_pend = 1'b0;
      end

      // Line events
      case (c_r.st)
         line_act_pkg::ST_PEND_DEACT: begin
            if (quiet_done) begin
               c_nxt.st = line_act_pkg::ST_WAIT_DR;
            end
         end
         line_act_pkg::ST_DEACT: begin
            if (rx_info1w) begin
               c_nxt.st = line_act_pkg::ST_PEND_ACT;
               c_nxt.wake = 1'b1;
            end
         end
         line_act_pkg::ST_PEND_ACT,
         line_act_pkg::ST_RESYNC: begin
            if (rx_info1) begin
               c_nxt.st = line_act_pkg::ST_SYNCED;
               c_nxt.good = '0;
            end
         end
         line_act_pkg::ST_SYNCED: begin
            if (rx_frame) begin
               if (rx_frame_cv) begin
                  c_nxt.good = '0;
               end else if (c_r.good == `GOOD_FRAMES - 2'h1) begin
                  c_nxt.st = line_act_pkg::ST_ACTIVATED;
               end else begin
                  c_nxt.good = c_r.good + 2'h1;
               end
            end
         end
         line_act_pkg::ST_ACTIVATED: begin
            if (rx_info3_lost) begin
               c_nxt.st = line_act_pkg::ST_RESYNC;
            end
         end
         default: begin
         end
      endcase

      // Commands at the frame boundary override line events
      if (cmd_now) begin
         case (c_r.cmd)
            `CMD_DEACT_REQ: begin
               c_nxt.st = line_act_pkg::ST_PEND_DEACT;
            end
            `CMD_SW_INIT: begin
               c_nxt.st = line_act_pkg::ST_RESET;
            end
            `CMD_TEST_SINGLE: begin
               c_nxt.st = line_act_pkg::ST_TEST;
               c_nxt.tmode = line_act_pkg::TM_SINGLE;
            end
            `CMD_TEST_CONT: begin
               c_nxt.st = line_act_pkg::ST_TEST;
               c_nxt.tmode = line_act_pkg::TM_CONT;
            end
            `CMD_ACT_REQ,
            `CMD_ACT_LOOP2: begin
               if (c_r.st == line_act_pkg::ST_WAIT_DR ||
                   c_r.st == line_act_pkg::ST_DEACT) begin
                  c_nxt.st = line_act_pkg::ST_PEND_ACT;
                  c_nxt.wake = 1'b0;
                  c_nxt.tbit = (c_r.cmd == `CMD_ACT_LOOP2);
               end
            end
            `CMD_ACT_BLOCKED: begin
               if (c_r.st == line_act_pkg::ST_SYNCED ||
                   c_r.st == line_act_pkg::ST_RESYNC ||
                   c_r.st == line_act_pkg::ST_ACTIVATED) begin
                  c_nxt.st = line_act_pkg::ST_ACTIVATED;
                  c_nxt.tbit = 1'b0;
               end
            end
            `CMD_DEACT_CONFIRM: begin
               if (c_r.st == line_act_pkg::ST_PEND_DEACT) begin
                  c_nxt.st = line_act_pkg::ST_WAIT_DR;
               end else if (c_r.st == line_act_pkg::ST_WAIT_DR) begin
                  c_nxt.st = line_act_pkg::ST_DEACT;
               end
            end
            default: begin
            end
         endcase
      end

      if (c_nxt.st != line_act_pkg::ST_TEST) begin
         c_nxt.tmode = line_act_pkg::TM_OFF;
      end

      // Registered line controls follow the next state
      c_nxt.info = info_of(c_nxt.st);
      c_nxt.awake = !is_uncond(c_nxt.st);

      // Indication only on change
      ind_new = ind_of(c_nxt.st, c_nxt.wake);
      if (ind_new != c_r.ind) begin
         c_nxt.ind = ind_new;
         c_nxt.ind_vld = 1'b1;
      end

      if (rx_frame) begin
         c_nxt.framing_violation_flag = rx_frame_cv;
      end

      // Serial status: load snapshot, then shift out LSB first
      if (stat_load) begin
         c_nxt.word = stat_now;
         c_nxt.sh = stat_now;
      end else begin
         c_nxt.sh = {1'b0, c_r.sh[31:1]};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         c_r <= '0;
      end else begin
         c_r <= c_nxt;
      end
   end

   assign ind_code     = c_r.ind;
   assign ind_strobe   = c_r.ind_vld;
   assign tx_info      = c_r.info;
   assign tx_t_bit     = c_r.tbit;
   assign awake_det_en = c_r.awake;
   assign stat_sdo     = c_r.sh[0];
   assign stat_word    = c_r.word;

   // ***********************************************************
   // Assertions
   // ***********************************************************

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   property p_reset_silent;
      c_r.st == line_act_pkg::ST_RESET |->
         tx_info == line_act_pkg::INFO_0 && !awake_det_en;
   endproperty
   a_reset_silent: assert property (p_reset_silent)
      else $error("reset state not silent");

   property p_sw_init;
      cmd_now && c_r.cmd == `CMD_SW_INIT |=>
         c_r.st == line_act_pkg::ST_RESET;
   endproperty
   a_sw_init: assert property (p_sw_init)
      else $error("init command did not reset");

   property p_test_pattern;
      cmd_now && c_r.cmd == `CMD_TEST_CONT |=>
         c_r.tmode == line_act_pkg::TM_CONT &&
         tx_info == line_act_pkg::INFO_TEST ##1 tx_pulse_neg != tx_pulse_pos;
   endproperty
   a_test_pattern: assert property (p_test_pattern)
      else $error("continuous test pattern missing");

   property p_deact_req;
      cmd_now && c_r.cmd == `CMD_DEACT_REQ |=>
         c_r.st == line_act_pkg::ST_PEND_DEACT &&
         tx_info == line_act_pkg::INFO_0 && awake_det_en;
   endproperty
   a_deact_req: assert property (p_deact_req)
      else $error("deactivate request not taken");

   property p_pend_deact_hold;
      c_r.st == line_act_pkg::ST_PEND_DEACT && !quiet_done && !cmd_now
         |=> c_r.st == line_act_pkg::ST_PEND_DEACT;
   endproperty
   a_pend_deact_hold: assert property (p_pend_deact_hold)
      else $error("pending deactivation left early");

   property p_uncond_exit;
      is_uncond(c_r.st) |=>
         is_uncond(c_r.st) || c_r.st == line_act_pkg::ST_PEND_DEACT;
   endproperty
   a_uncond_exit: assert property (p_uncond_exit)
      else $error("unconditional state left wrongly");

   property p_wake;
      c_r.st == line_act_pkg::ST_DEACT && rx_info1w && !cmd_now |=>
         c_r.st == line_act_pkg::ST_PEND_ACT && ind_strobe &&
         ind_code == `IND_ACT_REQ && tx_info == line_act_pkg::INFO_2;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake signal not answered");

   property p_two_frames;
      c_r.st == line_act_pkg::ST_SYNCED && !cmd_now && !rx_info1 &&
      c_r.good == 2'h1 && rx_frame && !rx_frame_cv |=>
         c_r.st == line_act_pkg::ST_ACTIVATED &&
         tx_info == line_act_pkg::INFO_4;
   endproperty
   a_two_frames: assert property (p_two_frames)
      else $error("activation after two frames missing");

   property p_resync;
      c_r.st == line_act_pkg::ST_ACTIVATED && rx_info3_lost && !cmd_now
         |=> ind_code == `IND_UNLOCKED && tx_info == line_act_pkg::INFO_2;
   endproperty
   a_resync: assert property (p_resync)
      else $error("resynchronization not entered");

   property p_ind_change;
      ind_strobe |-> ind_code != $past(ind_code);
   endproperty
   a_ind_change: assert property (p_ind_change)
      else $error("indication repeated");

   c_activated: cover property (c_r.st == line_act_pkg::ST_ACTIVATED);
   c_resync:    cover property (c_r.st == line_act_pkg::ST_RESYNC);
   c_test:      cover property (c_r.tmode == line_act_pkg::TM_SINGLE);
   c_quiet:     cover property (quiet_done);

endmodule
`default_nettype wire

/* tb/remote_terminal.sv */
// Remote terminal model on the far side of the line
`timescale 1ns/1ps
`default_nettype none

module remote_terminal (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   // Device transmit and scenario control
   input  wire logic [2:0] tx_info,
   input  wire logic       wake,
   input  wire logic       drop,
   input  wire logic       slow,
   // Line indications to the device
   output logic            frame_tick,
   output logic            rx_signal,
   output logic            rx_info1w,
   output logic            rx_info1,
   output logic            rx_frame,
   output logic            rx_frame_cv,
   output logic            rx_info3_lost
);
   logic [3:0] fc;
   logic [3:0] n;
   logic [3:0] lag;
   logic [1:0] snd;

   // ****************************************
   // Silence, two frames of INFO 1, then INFO 3
   // ****************************************
   assign lag = slow ? 4'h4 : 4'h0;
   assign snd = ((tx_info != 3'h2 && tx_info != 3'h4) || n < lag) ? 2'h0 :
                (n < lag + 4'h2 && tx_info == 3'h2) ? 2'h1 : 2'h3;

   always_ff @(posedge sys_clk) begin
      fc <= rstn ? fc + 4'h1 : 4'h0;
      frame_tick <= rstn && fc == 4'hF;
      if (!rstn || drop || tx_info == 3'h0) begin
         n <= 4'h0;
      end else if (fc == 4'hF && n != 4'hF) begin
         n <= n + 4'h1;
      end
      rx_frame <= rstn && fc == 4'hF && snd != 2'h0;
      rx_frame_cv <= snd == 2'h1;
      rx_info1 <= rstn && snd == 2'h1;
      rx_info1w <= rstn && wake;
      rx_signal <= rstn && (snd != 2'h0 || wake);
      rx_info3_lost <= rstn && drop;
   end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench of the line activation state machine
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic        sys_clk = 1'b0;
   logic        rstn = 1'b0;
   logic [3:0]  cmd_code = 4'h0;
   logic        cmd_strobe = 1'b0;
   logic        wake = 1'b0;
   logic        drop = 1'b0;
   logic        slow = 1'b0;
   logic [1:0]  mon_bits = 2'h2;
   logic        far_end_violation_flag = 1'b1;
   logic        slip_flag = 1'b0;
   logic        multiframe_lock_flag = 1'b1;
   logic        stat_load = 1'b0;
   logic [3:0]  ind_code;
   logic [3:0]  ind_prev = 4'h0;
   logic        ind_strobe;
   logic [2:0]  tx_info;
   logic        tx_t_bit, tx_pulse_pos, tx_pulse_neg, awake_det_en, stat_sdo;
   logic        frame_tick, rx_signal, rx_info1w, rx_info1, rx_frame;
   logic        rx_frame_cv, rx_info3_lost;
   logic [31:0] stat_word;
   logic [31:0] s;
   int          err_total = 0;
   int          samples_checked = 0;
   int          p, q;
   // Command, wake/drop/slow, wait, expected tx_info, expected indication
   logic [31:0] rows [12] = '{
      32'h10_0_078_0_F, 32'h1F_0_028_0_0, 32'h00_5_028_2_8, 32'h00_1_190_4_C,
      32'h00_3_01E_2_4, 32'h00_2_190_4_C, 32'h12_0_028_7_0, 32'h18_0_028_7_0,
      32'h13_0_028_7_0, 32'h10_0_078_0_F, 32'h18_1_028_2_0, 32'h11_0_028_0_0};

   always #4 sys_clk = ~sys_clk;

   line_activation_state_machine #(.QUIET_CYC(20), .SLOW_CYC(700))
      i_line_activation_state_machine (.sys_clk, .rstn, .cmd_code,
      .cmd_strobe, .ind_code, .ind_strobe, .frame_tick, .rx_signal,
      .rx_info1w, .rx_info1, .rx_frame, .rx_frame_cv, .rx_info3_lost,
      .tx_info, .tx_t_bit, .tx_pulse_pos, .tx_pulse_neg, .awake_det_en,
      .mon_bits, .far_end_violation_flag, .slip_flag, .multiframe_lock_flag,
      .stat_load, .stat_sdo, .stat_word);
   remote_terminal i_remote_terminal (.sys_clk, .rstn, .tx_info, .wake,
      .drop, .slow, .frame_tick, .rx_signal, .rx_info1w, .rx_info1,
      .rx_frame, .rx_frame_cv, .rx_info3_lost);

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic cmd(input logic [3:0] c, input int wt);
      @(posedge sys_clk);
      cmd_code <= c;
      cmd_strobe <= 1'b1;
      @(posedge sys_clk);
      cmd_strobe <= 1'b0;
      tick(wt);
      #1;
   endtask

   task automatic count(input int n, output int a, output int b);
      a = 0;
      b = 0;
      repeat (n) begin
         @(posedge sys_clk);
         #1;
         a += int'(tx_pulse_pos);
         b += int'(tx_pulse_neg);
      end
   endtask

   task automatic close_out;
      $display("Compared %0d values, %0d mismatches", samples_checked,
               err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Strobe must mark exactly the cycles in which the indication changes
   always @(negedge sys_clk) begin
      if (rstn) begin
         chk("ind strobe", 32'(ind_code != ind_prev), 32'(ind_strobe));
      end
      ind_prev = ind_code;
   end

   initial begin
      tick(60000);
      err_total++;
      close_out;
   end

   // ****************************************
   // Table of ordinary cases, then hand tests
   // ****************************************
   initial begin
      tick(4);
      rstn <= 1'b1;
      foreach (rows[i]) begin
         @(posedge sys_clk);
         cmd_code <= rows[i][27:24];
         cmd_strobe <= rows[i][28];
         wake <= rows[i][22];
         drop <= rows[i][21];
         slow <= rows[i][20];
         @(posedge sys_clk);
         cmd_strobe <= 1'b0;
         wake <= 1'b0;
         drop <= 1'b0;
         tick(int'(rows[i][19:8]));
         #1;
         chk("tx info", 32'(rows[i][7:4]), 32'(tx_info));
         chk("indication", 32'(rows[i][3:0]), 32'(ind_code));
      end
      chk("reset detector", 32'h0, 32'(awake_det_en));
      @(posedge sys_clk);
      wake <= 1'b1;
      cmd(4'h0, 60);
      chk("held pending", 32'h0, 32'(ind_code));
      chk("pending detector", 32'h1, 32'(awake_det_en));
      @(posedge sys_clk);
      wake <= 1'b0;
      tick(60);
      #1;
      chk("quiet end", 32'hF, 32'(ind_code));
      cmd(4'hF, 40);
      chk("deact detector", 32'h1, 32'(awake_det_en));
      @(posedge sys_clk);
      wake <= 1'b1;
      slow <= 1'b0;
      @(posedge sys_clk);
      wake <= 1'b0;
      tick(400);
      @(posedge sys_clk);
      stat_load <= 1'b1;
      @(posedge sys_clk);
      stat_load <= 1'b0;
      #1;
      chk("status word", 32'h0000_00AE, stat_word);
      for (int i = 0; i < 32; i++) begin
         s[i] = stat_sdo;
         @(posedge sys_clk);
         #1;
      end
      chk("status serial", 32'h0000_00AE, s);
      cmd(4'hC, 40);
      chk("blocked info", 32'h4, 32'(tx_info));
      chk("blocked t bit", 32'h0, 32'(tx_t_bit));
      cmd(4'h0, 120);
      slow <= 1'b1;
      cmd(4'hA, 30);
      chk("loop info", 32'h2, 32'(tx_info));
      chk("loop t bit", 32'h1, 32'(tx_t_bit));
      cmd(4'h3, 400);
      count(1300, p, q);
      chk("cont pulses", 32'h1, 32'(p >= 648 && p <= 652));
      cmd(4'h2, 1500);
      count(1400, p, q);
      chk("single pos", 32'h1, 32'(p >= 323 && p <= 327));
      chk("single neg", 32'h1, 32'(q >= 323 && q <= 327));
      @(posedge sys_clk);
      rstn <= 1'b0;
      tick(4);
      #1;
      chk("reset info", 32'h0, 32'(tx_info));
      chk("reset det", 32'h0, 32'(awake_det_en));
      @(posedge sys_clk);
      rstn <= 1'b1;
      close_out;
   end
endmodule
`default_nettype wire
